// ---- hw/lcpf_pkg.sv ----
// Shared constants, types and decode functions of the packet formatter
`default_nettype none
package lcpf_pkg;

  // ----------------------------------------------------------------------
  // Link geometry and timing
  // ----------------------------------------------------------------------
  localparam int LINK_W_DEF  = 8;
  localparam int MCLK_NS     = 100;
  localparam int LCLK_NS     = 800;
  localparam int LCLK_HALF   = LCLK_NS / MCLK_NS / 2;
  localparam int DIV_W       = 8;
  localparam int BT_W        = 6;
  localparam int SHORT_BYTES = 4;
  localparam int LONG_BYTES  = 8;
  localparam int PKT_BITS    = LONG_BYTES * 8;
  localparam int DW_BITS     = SHORT_BYTES * 8;

  // ----------------------------------------------------------------------
  // Command codes and field values
  // ----------------------------------------------------------------------
  localparam logic [5:0] CMD_NOP      = 6'h00;
  localparam logic [5:0] CMD_FLUSH    = 6'h02;
  localparam logic [5:0] CMD_RD_RESP  = 6'h30;
  localparam logic [5:0] CMD_TGT_DONE = 6'h33;
  localparam logic [5:0] CMD_BCAST    = 6'h3a;
  localparam logic [5:0] CMD_FENCE    = 6'h3c;
  localparam logic [5:0] CMD_ATOMIC   = 6'h3d;
  localparam logic [4:0] HOST_BRIDGE_ID = 5'h00;
  localparam logic [3:0] NO_SEQ         = 4'h0;
  localparam logic [PKT_BITS-1:0] NOP_PKT = 64'h0;

  // ----------------------------------------------------------------------
  // Field positions in the flat packet, byte n at bits 8n+7..8n
  // ----------------------------------------------------------------------
  localparam int SEQ_HI_POS  = 6;
  localparam int SID_POS     = 8;
  localparam int SEQ_LO_POS  = 13;
  localparam int BRIDGE_POS  = 14;
  localparam int PASS_POS    = 15;
  localparam int TAG_POS     = 16;
  localparam int REQ_CNT_POS = 21;
  localparam int ERR_POS     = 24;
  localparam int RSP_CNT_POS = 25;
  localparam int ADDR_POS    = 26;
  localparam int NOADDR_POS  = 29;

  typedef enum logic [2:0] {
    KIND_INFO = 3'b001,
    KIND_REQ  = 3'b010,
    KIND_RESP = 3'b100
  } lcpf_kind_t;

  function automatic lcpf_kind_t pkt_kind(input logic [5:0] c);
    if (c == CMD_NOP) return KIND_INFO;
    if (c == CMD_RD_RESP || c == CMD_TGT_DONE) return KIND_RESP;
    return KIND_REQ;
  endfunction

  function automatic logic has_addr(input logic [5:0] c);
    return (c[4:3] == 2'b01) || (c[5:4] == 2'b01) ||
           (c == CMD_BCAST) || (c == CMD_ATOMIC);
  endfunction

  function automatic logic is_posted(input logic [5:0] c);
    return (c[5:3] == 3'b101) || (c == CMD_BCAST) || (c == CMD_FENCE);
  endfunction

  function automatic logic has_data(input logic [5:0] c);
    return (c[4:3] == 2'b01) || (c == CMD_RD_RESP) || (c == CMD_ATOMIC);
  endfunction

  function automatic int pkt_bytes(input logic [5:0] c);
    return (pkt_kind(c) == KIND_REQ && has_addr(c)) ? LONG_BYTES
                                                    : SHORT_BYTES;
  endfunction

  function automatic logic [2:0] dw_count(input logic [PKT_BITS-1:0] p);
    return (pkt_kind(p[5:0]) == KIND_RESP) ? p[RSP_CNT_POS +: 3]
                                           : p[REQ_CNT_POS +: 3];
  endfunction

endpackage
`default_nettype wire

// ---- hw/lcpf_link_if.sv ----
// One direction of the packet link between two nodes
`timescale 1ns/1ps
`default_nettype none
interface lcpf_link_if #(
  parameter int LINK_W = lcpf_pkg::LINK_W_DEF
);
  logic              linkClk;
  logic              framing;
  logic [LINK_W-1:0] lanes;

  modport tx_end (output linkClk, output framing, output lanes);
  modport rx_end (input linkClk, input framing, input lanes);
endinterface
`default_nettype wire

// ---- hw/lcpf_node_tx.sv ----
// Transmitting node: formats info, request, response and data packets
//
// Functional notes
// - every packet a multiple of four bytes
// - control packets four or eight bytes
// - command in bits 5..0 of bit-time 0
// - stream id zero means host bridge
// - bridge bit only from host bridge
// - equal nonzero sequence tags stay ordered
// - forwarded same-tag requests keep their order
// - pass-posted flag may overtake posted requests
// - transaction tag pairs request and response
// - address carries doubleword bits 39..2
// - originated reserved fields driven zero
// - forwarded packets keep reserved fields unchanged
// - info packets always accepted, never refused
// - request eight bytes with address, else four
// - request layout of tags, stream, address
// - response layout of flags and stream
// - error bit qualifies the no-address flag
// - no-address flag: nobody claimed the request
// - framing high in control, low in data
// - wide links concatenate, narrow links slice bytes
// - codes for null, read response, target done
`timescale 1ns/1ps
`default_nettype none
module lcpf_node_tx #(
  parameter int LINK_W         = lcpf_pkg::LINK_W_DEF,
  parameter bit IS_HOST_BRIDGE = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  lcpf_link_if.tx_end      link,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic [5:0]  cmd,
  input  wire logic [3:0]  seqTag,
  input  wire logic        passPosted,
  input  wire logic [4:0]  streamId,
  input  wire logic [4:0]  txnTag,
  input  wire logic [39:2] addr,
  input  wire logic [2:0]  dwCount,
  input  wire logic        respError,
  input  wire logic        nonExistFlag,
  input  wire logic        toFarHost,
  input  wire logic        fwdMode,
  input  wire logic [63:0] fwdPkt,
  input  wire logic        dataValid,
  output logic             dataReady,
  input  wire logic [31:0] dataWord
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int BTW = lcpf_pkg::BT_W;
  localparam logic [BTW-1:0] BT4_CNT =
    BTW'(lcpf_pkg::DW_BITS / LINK_W);
  localparam logic [BTW-1:0] BT8_CNT =
    BTW'(lcpf_pkg::PKT_BITS / LINK_W);
  localparam logic [lcpf_pkg::DIV_W-1:0] HALF_M1 =
    lcpf_pkg::DIV_W'(lcpf_pkg::LCLK_HALF - 1);

  logic [lcpf_pkg::DIV_W-1:0] divCnt;
  logic                       clkQ;
  logic                       fallEv;
  logic                       lastBt;
  logic                       takeReq;
  logic                       takeData;
  logic [63:0]                shreg;
  logic [63:0]                built;
  logic [63:0]                next_pkt;
  logic [BTW-1:0]             btLeft;
  logic [BTW-1:0]             next_len;
  logic                       frmQ;
  logic                       next_frm;
  logic [3:0]                 dwLeft;
  logic [5:0]                 selCmd;
  logic                       bridgeBit;
  lcpf_pkg::lcpf_kind_t       kind;

  // ----------------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------------
  // Lanes change on the falling edge so the far end samples mid-bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt <= '0;
      clkQ   <= 1'b0;
    end else if (divCnt == HALF_M1) begin
      divCnt <= '0;
      clkQ   <= ~clkQ;
    end else begin
      divCnt <= divCnt + 1'b1;
    end
  end

  assign fallEv = (divCnt == HALF_M1) && clkQ;
  assign lastBt = (btLeft == BTW'(1));

  // ----------------------------------------------------------------------
  // Packet boundary handshakes
  // ----------------------------------------------------------------------
  // single issue, strict acceptance order
  // forwarded requests leave in arrival order
  assign reqReady  = fallEv && lastBt && (dwLeft == 4'h0);
  assign takeReq   = reqReady && reqValid;
  assign dataReady = fallEv && lastBt && (dwLeft != 4'h0);
  assign takeData  = dataReady && dataValid;

  assign selCmd = fwdMode ? fwdPkt[5:0] : cmd;
  // bridge set only by host bridge
  assign bridgeBit = IS_HOST_BRIDGE && !toFarHost;

  // ----------------------------------------------------------------------
  // Control packet assembly
  // ----------------------------------------------------------------------
  always_comb begin
    kind  = lcpf_pkg::pkt_kind(cmd);
    built = '0;
    built[5:0] = cmd;
    case (kind)
      lcpf_pkg::KIND_REQ: begin
        built[lcpf_pkg::SEQ_HI_POS +: 2] = seqTag[3:2];
        built[lcpf_pkg::SEQ_LO_POS +: 2] = seqTag[1:0];
        built[lcpf_pkg::SID_POS +: 5]    = streamId;
        built[lcpf_pkg::PASS_POS]        = passPosted;
        // tag is reserved for posted requests
        if (!lcpf_pkg::is_posted(cmd)) begin
          built[lcpf_pkg::TAG_POS +: 5] = txnTag;
        end
        if (lcpf_pkg::has_data(cmd)) begin
          built[lcpf_pkg::REQ_CNT_POS +: 3] = dwCount;
        end
        if (lcpf_pkg::has_addr(cmd)) begin
          built[63:lcpf_pkg::ADDR_POS] = addr;
        end
      end
      lcpf_pkg::KIND_RESP: begin
        built[lcpf_pkg::PASS_POS]     = passPosted;
        built[lcpf_pkg::BRIDGE_POS]   = bridgeBit;
        built[lcpf_pkg::SID_POS +: 5] = streamId;
        built[lcpf_pkg::TAG_POS +: 5] = txnTag;
        built[lcpf_pkg::ERR_POS]      = respError;
        built[lcpf_pkg::NOADDR_POS]   = respError && nonExistFlag;
        if (cmd == lcpf_pkg::CMD_RD_RESP) begin
          built[lcpf_pkg::RSP_CNT_POS +: 3] = dwCount;
        end
      end
      default: begin
        // Info packets carry only their command here
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next unit selection
  // ----------------------------------------------------------------------
  always_comb begin
    // null info fills every idle slot
    // null code when nothing else is due
    next_frm = 1'b1;
    next_pkt = lcpf_pkg::NOP_PKT;
    next_len = BT4_CNT;
    if (takeData) begin
      // data words go out with framing low
      next_frm = 1'b0;
      next_pkt = {32'h0, dataWord};
    end else if (takeReq) begin
      // forwarded packets go out bit for bit
      next_pkt = fwdMode ? fwdPkt : built;
      if (lcpf_pkg::pkt_bytes(selCmd) == lcpf_pkg::LONG_BYTES) begin
        next_len = BT8_CNT;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pending data words
  // ----------------------------------------------------------------------
  // A stalled data source gets null packets inserted, the link never stops
  always_ff @(posedge mclk) begin
    if (rst) begin
      dwLeft <= 4'h0;
    end else if (takeReq && lcpf_pkg::has_data(selCmd)) begin
      dwLeft <= {1'b0, lcpf_pkg::dw_count(next_pkt)} + 4'h1;
    end else if (takeData) begin
      dwLeft <= dwLeft - 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Bit-time serialiser
  // ----------------------------------------------------------------------
  // units end only on four-byte boundaries
  // lowest bits first, LINK_W per bit-time
  always_ff @(posedge mclk) begin
    if (rst) begin
      shreg  <= lcpf_pkg::NOP_PKT;
      btLeft <= BT4_CNT;
      frmQ   <= 1'b1;
    end else if (fallEv) begin
      if (lastBt) begin
        shreg  <= next_pkt;
        btLeft <= next_len;
        frmQ   <= next_frm;
      end else begin
        shreg  <= shreg >> LINK_W;
        btLeft <= btLeft - 1'b1;
      end
    end
  end

  assign link.linkClk = clkQ;
  // framing held for the whole unit
  assign link.framing = frmQ;
  assign link.lanes   = shreg[LINK_W-1:0];

endmodule // lcpf_node_tx
`default_nettype wire

// ---- hw/lcpf_peer_rx.sv ----
// Receiving node: samples the link and decodes packet fields
`timescale 1ns/1ps
`default_nettype none
module lcpf_peer_rx #(
  parameter int LINK_W = lcpf_pkg::LINK_W_DEF
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  lcpf_link_if.rx_end          link,
  output logic                 pktValid,
  output lcpf_pkg::lcpf_kind_t pktKind,
  output logic [5:0]           cmd,
  output logic [3:0]           seqTag,
  output logic                 passPosted,
  output logic                 bridge,
  output logic [4:0]           streamId,
  output logic                 fromHostBridge,
  output logic [4:0]           txnTag,
  output logic [39:2]          addr,
  output logic                 respError,
  output logic                 noAgent,
  output logic                 targetFail,
  output logic [63:0]          pktRaw,
  output logic                 dataValid,
  output logic [31:0]          dataWord,
  output logic                 framingErr
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int BTW = lcpf_pkg::BT_W;
  localparam logic [BTW-1:0] BT4_M1 =
    BTW'(lcpf_pkg::DW_BITS / LINK_W - 1);
  localparam logic [BTW-1:0] BT8_M1 =
    BTW'(lcpf_pkg::PKT_BITS / LINK_W - 1);

  logic [2:0]        clkSync;
  logic [1:0]        frmSync;
  logic [LINK_W-1:0] laneS1;
  logic [LINK_W-1:0] laneS2;
  logic              riseEv;

  always_ff @(posedge mclk) begin
    clkSync <= {clkSync[1:0], link.linkClk};
    frmSync <= {frmSync[0], link.framing};
    laneS1  <= link.lanes;
    laneS2  <= laneS1;
  end

  assign riseEv = clkSync[1] && !clkSync[2];

  // ----------------------------------------------------------------------
  // Bit-time assembly
  // ----------------------------------------------------------------------
  logic [63:0]    acc;
  logic [63:0]    n;
  logic [BTW-1:0] btIdx;
  logic           unitFrm;
  logic           frmQ;
  logic           done;
  logic [3:0]     dwPend;

  always_comb begin
    n = acc;
    // each bit-time fills the next LINK_W bits
    n[int'(btIdx) * LINK_W +: LINK_W] = laneS2;
    unitFrm = (btIdx == '0) ? frmSync[1] : frmQ;
    // control units end at four or eight bytes
    // long form only with an address
    done = (btIdx == BT8_M1) ||
           ((btIdx == BT4_M1) && (!unitFrm ||
            lcpf_pkg::pkt_bytes(n[5:0]) == lcpf_pkg::SHORT_BYTES));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc   <= '0;
      btIdx <= '0;
      frmQ  <= 1'b1;
    end else if (riseEv) begin
      acc   <= n;
      frmQ  <= unitFrm;
      btIdx <= done ? '0 : btIdx + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  // no ready here, info is always taken
  // reserved bits reach no decoded field except txnTag, from the reserved tag bits of posted requests, and streamId, fromHostBridge and txnTag of info packets
  always_ff @(posedge mclk) begin
    if (rst) begin
      pktValid       <= 1'b0;
      pktKind        <= lcpf_pkg::KIND_INFO;
      cmd            <= lcpf_pkg::CMD_NOP;
      seqTag         <= lcpf_pkg::NO_SEQ;
      passPosted     <= 1'b0;
      bridge         <= 1'b0;
      streamId       <= 5'h00;
      fromHostBridge <= 1'b0;
      txnTag         <= 5'h00;
      addr           <= '0;
      respError      <= 1'b0;
      noAgent        <= 1'b0;
      targetFail     <= 1'b0;
      pktRaw         <= '0;
    end else begin
      pktValid <= riseEv && done && unitFrm;
      if (riseEv && done && unitFrm) begin
        // type taken from the command field
        // null, read response and target done codes
        pktKind    <= lcpf_pkg::pkt_kind(n[5:0]);
        cmd        <= n[5:0];
        // sequence tag handed on for ordering
        // request tag bits from two bytes
        seqTag     <= (lcpf_pkg::pkt_kind(n[5:0]) == lcpf_pkg::KIND_REQ)
                      ? {n[lcpf_pkg::SEQ_HI_POS +: 2],
                         n[lcpf_pkg::SEQ_LO_POS +: 2]}
                      : lcpf_pkg::NO_SEQ;
        passPosted <= (n[5:0] != lcpf_pkg::CMD_NOP) &&
                      n[lcpf_pkg::PASS_POS];
        bridge     <= (lcpf_pkg::pkt_kind(n[5:0]) == lcpf_pkg::KIND_RESP) &&
                      n[lcpf_pkg::BRIDGE_POS];
        streamId   <= n[lcpf_pkg::SID_POS +: 5];
        // stream zero belongs to the host bridge
        fromHostBridge <= (n[lcpf_pkg::SID_POS +: 5] ==
                           lcpf_pkg::HOST_BRIDGE_ID);
        txnTag     <= n[lcpf_pkg::TAG_POS +: 5];
        addr       <= lcpf_pkg::has_addr(n[5:0]) ? n[63:lcpf_pkg::ADDR_POS]
                                                 : '0;
        respError  <= (lcpf_pkg::pkt_kind(n[5:0]) == lcpf_pkg::KIND_RESP) &&
                      n[lcpf_pkg::ERR_POS];
        // no-address flag read only with error
        noAgent    <= (lcpf_pkg::pkt_kind(n[5:0]) == lcpf_pkg::KIND_RESP) &&
                      n[lcpf_pkg::ERR_POS] && n[lcpf_pkg::NOADDR_POS];
        targetFail <= (lcpf_pkg::pkt_kind(n[5:0]) == lcpf_pkg::KIND_RESP) &&
                      n[lcpf_pkg::ERR_POS] && !n[lcpf_pkg::NOADDR_POS];
        pktRaw     <= n;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data words and framing checks
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      dwPend     <= 4'h0;
      dataValid  <= 1'b0;
      dataWord   <= 32'h0;
      framingErr <= 1'b0;
    end else begin
      dataValid  <= 1'b0;
      // framing must not change inside a unit
      framingErr <= riseEv && (btIdx != '0) && (frmSync[1] != frmQ);
      if (riseEv && done && unitFrm &&
          lcpf_pkg::has_data(n[5:0])) begin
        dwPend <= {1'b0, lcpf_pkg::dw_count(n)} + 4'h1;
      end else if (riseEv && done && !unitFrm) begin
        // data moves in whole four-byte words
        if (dwPend == 4'h0) begin
          framingErr <= 1'b1;
        end else begin
          dwPend    <= dwPend - 4'h1;
          dataValid <= 1'b1;
          dataWord  <= n[31:0];
        end
      end
    end
  end

endmodule // lcpf_peer_rx
`default_nettype wire

// ---- sim/lcpf_link_assertions.sv ----
// Wire-level checks of one packet link direction
`timescale 1ns/1ps
`default_nettype none
module lcpf_link_assertions #(
  parameter int LINK_W = lcpf_pkg::LINK_W_DEF
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              linkClk,
  input wire logic              framing,
  input wire logic [LINK_W-1:0] lanes
);
  // ------------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------------
  localparam int UNIT_BT  = 32 / LINK_W;
  localparam int UNIT_CYC = UNIT_BT * 2 * lcpf_pkg::LCLK_HALF;
  logic [5:0] btCnt;
  logic [9:0] ctlRun;

  // Bit-times counted from reset, since the link has no training
  always_ff @(posedge mclk) begin
    if (rst) btCnt <= '0;
    else if ($fell(linkClk))
      btCnt <= (btCnt == 6'(UNIT_BT - 1)) ? '0 : btCnt + 6'h01;
  end

  always_ff @(posedge mclk) begin
    if (rst || !framing) ctlRun <= '0;
    else if (ctlRun != '1) ctlRun <= ctlRun + 10'h001;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_frame_aligned;
    $changed(framing) |-> btCnt == 6'(UNIT_BT - 1);
  endproperty
  property p_frame_on_edge;
    $changed(framing) |-> $fell(linkClk);
  endproperty
  property p_lanes_on_edge;
    !$stable(lanes) |-> $fell(linkClk);
  endproperty
  property p_lanes_hold;
    $fell(linkClk) |=> $stable(lanes)[*7];
  endproperty
  property p_clk_high;
    $rose(linkClk) |-> linkClk[*4] ##1 !linkClk;
  endproperty
  property p_clk_low;
    $fell(linkClk) |-> !linkClk[*4] ##1 linkClk;
  endproperty
  property p_clk_runs;
    !linkClk |-> ##[1:8] linkClk;
  endproperty
  // A data unit follows at least one whole control unit
  property p_ctl_min;
    $fell(framing) |-> ctlRun >= 10'(UNIT_CYC - 8);
  endproperty

  a_frame_aligned: assert property (p_frame_aligned)
    else $error("framing moved off a four-byte boundary");
  a_frame_on_edge: assert property (p_frame_on_edge)
    else $error("framing moved inside a bit-time");
  a_lanes_on_edge: assert property (p_lanes_on_edge)
    else $error("lanes moved inside a bit-time");
  a_lanes_hold: assert property (p_lanes_hold)
    else $error("lanes not held for a bit-time");
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high phase wrong");
  a_clk_low: assert property (p_clk_low)
    else $error("link clock low phase wrong");
  a_clk_runs: assert property (p_clk_runs)
    else $error("link clock stopped");
  a_ctl_min: assert property (p_ctl_min)
    else $error("control unit shorter than four bytes");

  c_data_unit: cover property ($fell(framing));
  c_ctl_after: cover property ($rose(framing));
  c_long_ctl: cover property (ctlRun > 10'(UNIT_CYC + 8));
endmodule // lcpf_link_assertions
`default_nettype wire

// ---- sim/link_control_packet_formatter_tb.sv ----
// Bench: transmitting node drives receiving node across one link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module link_control_packet_formatter_tb;
  logic        mclk = 1'b0, rst = 1'b1, reqValid = 1'b0;
  logic        dataValid = 1'b0, tPass = 1'b0, tErr = 1'b0;
  logic        tNxa = 1'b0, tFar = 1'b0, tFwd = 1'b0;
  logic [5:0]  tCmd = '0;
  logic [3:0]  tSeq = '0;
  logic [4:0]  tSid = '0, tTag = '0;
  logic [39:2] tAddr = '0;
  logic [2:0]  tCnt = '0;
  logic [63:0] tFwdPkt = '0;
  logic [31:0] dataWord = '0, seed = 32'h000154eb;  // Seed 87275
  // Variables, so that the wait task can take them by reference
  logic        reqReady, dataReady, pktValid;
  wire logic   rPass, rBridge, rHost;
  wire logic   rErr, rNoAgent, rFail, rDv, fErr;
  wire lcpf_pkg::lcpf_kind_t pktKind;
  wire logic [5:0]  rCmd;
  wire logic [3:0]  rSeq;
  wire logic [4:0]  rSid, rTag;
  wire logic [39:2] rAddr;
  wire logic [63:0] rRaw;
  wire logic [31:0] rWord;
  int          mismatches = 0, checks_done = 0;
  logic [64:0] pq[$];
  logic [31:0] dq[$];
  localparam logic [5:0] CMDS [10] = '{6'h02, 6'h2d, 6'h0c, 6'h14,
    6'h3a, 6'h3c, 6'h3d, 6'h30, 6'h33, 6'h1f};

  initial forever #50 mclk = ~mclk;

  lcpf_link_if #(.LINK_W(8)) lcpf_link_if_i ();
  lcpf_node_tx #(.LINK_W(8), .IS_HOST_BRIDGE(1'b1)) lcpf_node_tx_i (
    .mclk(mclk), .rst(rst), .link(lcpf_link_if_i), .reqValid(reqValid),
    .reqReady(reqReady), .cmd(tCmd), .seqTag(tSeq), .passPosted(tPass),
    .streamId(tSid), .txnTag(tTag), .addr(tAddr), .dwCount(tCnt),
    .respError(tErr), .nonExistFlag(tNxa), .toFarHost(tFar),
    .fwdMode(tFwd), .fwdPkt(tFwdPkt), .dataValid(dataValid),
    .dataReady(dataReady), .dataWord(dataWord));
  lcpf_peer_rx #(.LINK_W(8)) lcpf_peer_rx_i (
    .mclk(mclk), .rst(rst), .link(lcpf_link_if_i), .pktValid(pktValid),
    .pktKind(pktKind), .cmd(rCmd), .seqTag(rSeq), .passPosted(rPass),
    .bridge(rBridge), .streamId(rSid), .fromHostBridge(rHost),
    .txnTag(rTag), .addr(rAddr), .respError(rErr), .noAgent(rNoAgent),
    .targetFail(rFail), .pktRaw(rRaw), .dataValid(rDv),
    .dataWord(rWord), .framingErr(fErr));
  lcpf_link_assertions #(.LINK_W(8)) lcpf_link_assertions_i (
    .mclk(mclk), .rst(rst), .linkClk(lcpf_link_if_i.linkClk),
    .framing(lcpf_link_if_i.framing), .lanes(lcpf_link_if_i.lanes));

  // ------------------------------------------------------------------
  // Expectation helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  function automatic logic isRsp(input logic [5:0] c);
    return c == 6'h30 || c == 6'h33;
  endfunction
  function automatic logic hasA(input logic [5:0] c);
    return c[4:3] == 2'b01 || c[5:4] == 2'b01 || c == 6'h3a || c == 6'h3d;
  endfunction
  function automatic logic hasD(input logic [5:0] c);
    return c[4:3] == 2'b01 || c == 6'h30 || c == 6'h3d;
  endfunction
  function automatic logic [2:0] ekind(input logic [5:0] c);
    return c == 6'h00 ? 3'b001 : (isRsp(c) ? 3'b100 : 3'b010);
  endfunction
  // Image of the packet the transmitter was just handed; bit 64 = long
  function automatic logic [64:0] img();
    logic [63:0] p;
    p = '0;
    p[5:0] = tCmd;
    p[12:8] = tSid;
    p[15] = tPass;
    p[20:16] = tTag;
    if (isRsp(tCmd)) begin
      p[14] = !tFar;
      p[24] = tErr;
      p[27:25] = tCnt;
      p[29] = tErr & tNxa;
    end else begin
      {p[7:6], p[14:13]} = tSeq;
      if (tCmd[5:3] == 3'b101 || tCmd == 6'h3a || tCmd == 6'h3c)
        p[20:16] = 5'h00;
      if (hasD(tCmd)) p[23:21] = tCnt;
      {p[63:32], p[31:26]} = tAddr;
    end
    return tFwd ? {1'b1, tFwdPkt} : {hasA(tCmd), p};
  endfunction

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin @(posedge mclk); n++; end while (s !== 1'b1 && n < 300);
  endtask

  // One packet; every tenth is forwarded verbatim with random reserved bits
  task automatic run_one(input int i);
    logic [31:0] r;
    logic [5:0]  c;
    r = rnd();
    c = CMDS[i % 10];
    @(posedge mclk);
    tFwd <= (i % 10 == 9);
    tFwdPkt <= {rnd(), r[31:8], 2'b01, 6'h14};
    tCmd <= c;
    tSeq <= isRsp(c) ? 4'h0 : r[3:0];
    tPass <= r[4];
    tSid <= (i < 10) ? 5'h00 : r[9:5];
    tTag <= r[14:10];
    tCnt <= (hasD(c) || c[5:4] == 2'b01) && c != 6'h33 ? r[17:15] : 3'h0;
    tErr <= r[18];
    tNxa <= r[19];
    tFar <= r[20];
    tAddr <= hasA(c) ? {rnd(), r[31:26]} : 38'h0;
    reqValid <= 1'b1;
    wait_hi(reqReady);
    `CHK("reqReady", 1'b1, reqReady)
    pq.push_back(img());
    reqValid <= 1'b0;
    if (i % 10 != 9 && hasD(c)) begin
      for (int w = 0; w <= tCnt; w++) begin
        r = rnd();
        if (r[1:0] == 2'b00) begin
          dataValid <= 1'b0;
          repeat (40) @(posedge mclk);
        end
        dataValid <= 1'b1;
        dataWord <= r;
        wait_hi(dataReady);
        `CHK("dataReady", 1'b1, dataReady)
        dq.push_back(r);
      end
      dataValid <= 1'b0;
    end
    $display("test %0d cmd %h done", i, c);
  endtask

  // ------------------------------------------------------------------
  // Receiver monitor
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    logic [64:0] e;
    logic [63:0] m;
    logic [31:0] d;
    if (!rst && fErr !== 1'b0) `CHK("framingErr", 1'b0, fErr)
    if (rDv === 1'b1) begin
      d = dq.pop_front();
      `CHK("dataWord", d, rWord)
    end
    if (pktValid === 1'b1 && pktKind !== lcpf_pkg::KIND_INFO) begin
      e = pq.pop_front();
      m = e[64] ? '1 : 64'h00000000ffffffff;
      `CHK("pktRaw", e[63:0] & m, rRaw & m)
      `CHK("kind", ekind(e[5:0]), pktKind)
      `CHK("cmd", e[5:0], rCmd)
      `CHK("streamId", e[12:8], rSid)
      `CHK("hostBridge", e[12:8] == 5'h00, rHost)
      `CHK("passPosted", e[15], rPass)
      `CHK("txnTag", e[20:16], rTag)
      if (isRsp(e[5:0])) begin
        `CHK("bridge", e[14], rBridge)
        `CHK("respError", e[24], rErr)
        `CHK("noAgent", e[24] & e[29], rNoAgent)
        `CHK("targetFail", e[24] & !e[29], rFail)
      end else begin
        `CHK("seqTag", {e[7:6], e[14:13]}, rSeq)
        `CHK("addr", e[64] ? {e[63:32], e[31:26]} : 38'h0, rAddr)
      end
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Forty packets of up to eight words each fit well inside this span
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    $display("[ERR] watchdog expired");
    close_out();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    wait_hi(pktValid);
    `CHK("firstValid", 1'b1, pktValid)
    `CHK("firstKind", 3'b001, pktKind)
    `CHK("firstCmd", lcpf_pkg::CMD_NOP, rCmd)
    for (int i = 0; i < 40; i++) run_one(i);
    repeat (400) @(posedge mclk);
    `CHK("pending", 0, pq.size() + dq.size())
    close_out();
  end
endmodule // link_control_packet_formatter_tb
`default_nettype wire
